// File: rtl/fprc_flash_ctrl.sv
// flash protection status, reset command/pin handling, sram and battery
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module fprc_flash_ctrl #(
  parameter int unsigned SMALL_RST_CYC = fprc_pkg::SMALL_RESET_CYC
) (
  input  wire logic        clk,              // system clock, 20 MHz
  input  wire logic        sys_rst,          // async reset, high
  input  wire logic        wb_cyc_i,         // wishbone cycle
  input  wire logic        wb_stb_i,         // wishbone strobe
  input  wire logic        wb_we_i,          // wishbone write
  input  wire logic [7:0]  wb_adr_i,         // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,         // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,         // wishbone write data
  output logic      [31:0] wb_dat_o,         // wishbone read data
  output logic             wb_ack_o,         // wishbone acknowledge
  output logic             irq,              // level interrupt
  input  wire logic        fl_wr,            // host flash write strobe
  input  wire logic [11:0] fl_adr,           // host flash write address
  input  wire logic [7:0]  fl_dat,           // host flash write data
  input  wire logic        prog_req,         // byte program request
  input  wire logic        bulk_req,         // bulk erase request
  input  wire logic        sect_req,         // sector erase request
  input  wire logic        tgt_secondary,    // target in secondary flash
  input  wire logic [2:0]  tgt_sector,       // target sector index
  input  wire logic        op_done,          // array engine finished
  input  wire logic        op_error,         // array engine failed
  input  wire logic        status_rd_req,    // enter status/id read mode
  input  wire logic [7:0]  prot_main,        // main sector protect bits
  input  wire logic [3:0]  prot_sec,         // secondary protect bits
  input  wire logic        security_set,     // security lock set
  input  wire logic        rst_pin_n,        // flash reset pin, low
  input  wire logic        large_variant,    // larger device timing
  input  wire logic [1:0]  sram_pt,          // decode logic product terms
  input  wire logic        supply_below_bat, // supply under battery
  input  wire logic        bat_powers_sram,  // battery feeds sram
  output logic             sram_en,          // sram enable
  output logic             batt_active,      // battery-active indicator
  output logic             array_read_mode,  // array reads decoded
  output logic             error_status_bit, // operation error flag
  output logic             op_go,            // start pulse to engine
  output logic      [1:0]  op_kind,          // kind of started op
  output logic             op_abort          // abort pulse to engine
);
  fprc_pkg::fprc_state_t state_r;
  logic                      ack_r;
  logic [31:0]               dat_r;
  logic [7:0]                ctrl_r;
  logic [fprc_pkg::IRQ_W-1:0] irq_stat_r;
  logic [fprc_pkg::IRQ_W-1:0] irq_en_r;
  logic                      error_r;
  logic                      id_mode_r;
  logic                      batt_r;
  logic                      go_r;
  logic [1:0]                kind_r;
  logic                      abort_r;
  logic                      rcmd;
  logic                      unlocked;
  logic                      tmr_load;
  logic [fprc_pkg::TMR_W-1:0] tmr_val;
  logic                      tmr_busy;
  logic                      tmr_done;
  logic                      pin_rst;
  logic                      in_op;
  logic                      start_ok;
  logic                      req_any;
  logic                      quick_ret;
  logic [31:0]               rd_mux;
  logic                      bus_req;
  logic [fprc_pkg::IRQ_W-1:0] ev;

  function automatic logic prot_hit(input logic sec, input logic [2:0] idx,
                                    input logic [7:0] pm,
                                    input logic [3:0] ps);
    prot_hit = sec ? ps[idx[1:0]] : pm[idx];
  endfunction

  fprc_cmd_decode u_dec (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .fl_wr     (fl_wr),
    .fl_adr    (fl_adr),
    .fl_dat    (fl_dat),
    .reset_cmd (rcmd),
    .unlocked  (unlocked)
  );

  fprc_timer u_tmr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  assign pin_rst = large_variant && !rst_pin_n;
  assign in_op   = (state_r == fprc_pkg::FPRC_PROG) ||
                   (state_r == fprc_pkg::FPRC_BULK) ||
                   (state_r == fprc_pkg::FPRC_SECT);
  assign req_any = prog_req || bulk_req || sect_req;
  // a bulk erase touching any protected sector is refused whole
  assign start_ok = array_read_mode && !rcmd &&
    (prog_req ? !prot_hit(tgt_secondary, tgt_sector, prot_main, prot_sec)
     : bulk_req ? (prot_main == 8'h00 && prot_sec == 4'h0)
     : sect_req && !prot_hit(tgt_secondary, tgt_sector, prot_main,
                             prot_sec));
  // large device with no error returns to array reads at once
  assign quick_ret = large_variant && !error_r;

  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val  = fprc_pkg::TMR_W'(fprc_pkg::RECOV_CYC);
    if (pin_rst && in_op)
      tmr_load = 1'b1;
    else if (rcmd && state_r == fprc_pkg::FPRC_SECT)
    begin
      tmr_load = 1'b1;
      if (!large_variant)
        tmr_val = fprc_pkg::TMR_W'(SMALL_RST_CYC);
    end
    else if (rcmd && state_r == fprc_pkg::FPRC_READ && !pin_rst &&
             !quick_ret)
    begin
      tmr_load = 1'b1;
      if (!large_variant)
        tmr_val = fprc_pkg::TMR_W'(SMALL_RST_CYC);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= fprc_pkg::FPRC_READ;
    else
    begin
      case (state_r)
        fprc_pkg::FPRC_READ:
        begin
          if (tmr_load)
            state_r <= fprc_pkg::FPRC_RECOV;
          else if (req_any && start_ok)
            state_r <= prog_req ? fprc_pkg::FPRC_PROG
                     : bulk_req ? fprc_pkg::FPRC_BULK : fprc_pkg::FPRC_SECT;
        end
        fprc_pkg::FPRC_PROG, fprc_pkg::FPRC_BULK:
        begin
          // a reset command here changes nothing
          if (pin_rst)
            state_r <= fprc_pkg::FPRC_RECOV;
          else if (op_error || op_done)
            state_r <= fprc_pkg::FPRC_READ;
        end
        fprc_pkg::FPRC_SECT:
        begin
          if (pin_rst || rcmd)
            state_r <= fprc_pkg::FPRC_RECOV;
          else if (op_error || op_done)
            state_r <= fprc_pkg::FPRC_READ;
        end
        fprc_pkg::FPRC_RECOV:
        begin
          if (tmr_done)
            state_r <= fprc_pkg::FPRC_READ;
        end
        default:
          state_r <= fprc_pkg::FPRC_READ;
      endcase
    end
  end

  // error and status-read modes persist until a reset recovers them
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      error_r   <= 1'b0;
      id_mode_r <= 1'b0;
    end
    else
    begin
      if (in_op && op_error && !pin_rst)
        error_r <= 1'b1;
      else if ((state_r == fprc_pkg::FPRC_RECOV && tmr_done) ||
               (rcmd && state_r == fprc_pkg::FPRC_READ && quick_ret))
        error_r <= 1'b0;
      if (status_rd_req && state_r == fprc_pkg::FPRC_READ)
        id_mode_r <= 1'b1;
      else if ((state_r == fprc_pkg::FPRC_RECOV && tmr_done) ||
               (rcmd && state_r == fprc_pkg::FPRC_READ && quick_ret))
        id_mode_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      go_r    <= 1'b0;
      kind_r  <= 2'h0;
      abort_r <= 1'b0;
    end
    else
    begin
      go_r    <= state_r == fprc_pkg::FPRC_READ && req_any && start_ok &&
                 !tmr_load;
      abort_r <= (pin_rst && in_op) ||
                 (rcmd && state_r == fprc_pkg::FPRC_SECT);
      if (state_r == fprc_pkg::FPRC_READ && req_any && start_ok)
        kind_r <= prog_req ? fprc_pkg::OP_PROG
                : bulk_req ? fprc_pkg::OP_BULK : fprc_pkg::OP_SECT;
    end
  end

  assign op_go            = go_r;
  assign op_kind          = kind_r;
  assign op_abort         = abort_r;
  assign error_status_bit = error_r;
  assign array_read_mode  = state_r == fprc_pkg::FPRC_READ && !error_r &&
                            !id_mode_r && !pin_rst;
  // the select itself is combinational so the sram follows it at once
  assign sram_en = |sram_pt;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      batt_r <= 1'b0;
    else
      batt_r <= ctrl_r[fprc_pkg::CTRL_BATT_EN_BIT] && supply_below_bat &&
                bat_powers_sram;
  end
  assign batt_active = batt_r;

  // wishbone slave: one wait state, unmapped reads return zero
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      fprc_pkg::ADR_MAIN_PROT: rd_mux[7:0] = prot_main;
      fprc_pkg::ADR_SEC_PROT:
      begin
        rd_mux[3:0] = prot_sec;
        rd_mux[fprc_pkg::SEC_SECURITY_BIT] = security_set;
      end
      fprc_pkg::ADR_CTRL: rd_mux[7:0] = ctrl_r;
      fprc_pkg::ADR_MODE:
      begin
        rd_mux[fprc_pkg::MODE_ARRAY_BIT] = array_read_mode;
        rd_mux[fprc_pkg::MODE_ERROR_BIT] = error_r;
        rd_mux[fprc_pkg::MODE_ID_BIT]    = id_mode_r;
        rd_mux[fprc_pkg::MODE_UNLK_BIT]  = unlocked;
        rd_mux[fprc_pkg::MODE_STATE_LSB +: 3] = state_r;
      end
      fprc_pkg::ADR_IRQ_STAT: rd_mux[fprc_pkg::IRQ_W-1:0] = irq_stat_r;
      fprc_pkg::ADR_IRQ_EN:   rd_mux[fprc_pkg::IRQ_W-1:0] = irq_en_r;
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i)
        dat_r <= rd_mux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // protection registers have no write path at all
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r   <= fprc_pkg::CTRL_RST;
      irq_en_r <= fprc_pkg::IRQ_EN_RST;
    end
    else if (bus_req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == fprc_pkg::ADR_CTRL)
        ctrl_r <= wb_dat_i[7:0];
      if (wb_adr_i == fprc_pkg::ADR_IRQ_EN)
        irq_en_r <= wb_dat_i[fprc_pkg::IRQ_W-1:0];
    end
  end

  always_comb
  begin
    ev = '0;
    ev[fprc_pkg::IRQ_DONE_BIT] = (state_r == fprc_pkg::FPRC_RECOV &&
      tmr_done) || (rcmd && state_r == fprc_pkg::FPRC_READ && quick_ret);
    ev[fprc_pkg::IRQ_IGN_BIT] = (rcmd && (state_r == fprc_pkg::FPRC_PROG ||
      state_r == fprc_pkg::FPRC_BULK)) ||
      (state_r == fprc_pkg::FPRC_READ && req_any && !start_ok);
    ev[fprc_pkg::IRQ_ERR_BIT] = in_op && op_error;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_stat_r <= '0;
    else if (bus_req && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == fprc_pkg::ADR_IRQ_CLR)
      irq_stat_r <= (irq_stat_r & ~wb_dat_i[fprc_pkg::IRQ_W-1:0]) | ev;
    else
      irq_stat_r <= irq_stat_r | ev;
  end
  assign irq = |(irq_stat_r & irq_en_r);

  property p_main_prot;
    @(posedge clk) disable iff (sys_rst)
    wb_ack_o && !wb_we_i && wb_adr_i == fprc_pkg::ADR_MAIN_PROT
      |-> wb_dat_o == {24'h0, $past(prot_main)};
  endproperty
  a_main_prot: assert property (p_main_prot)
    else $error("main protect read mismatch");

  property p_sec_prot;
    @(posedge clk) disable iff (sys_rst)
    wb_ack_o && !wb_we_i && wb_adr_i == fprc_pkg::ADR_SEC_PROT
      |-> wb_dat_o[3:0] == $past(prot_sec) && wb_dat_o[6:4] == 3'h0;
  endproperty
  a_sec_prot: assert property (p_sec_prot)
    else $error("secondary protect read mismatch");

  property p_security;
    @(posedge clk) disable iff (sys_rst)
    wb_ack_o && !wb_we_i && wb_adr_i == fprc_pkg::ADR_SEC_PROT
      |-> wb_dat_o[7] == $past(security_set);
  endproperty
  a_security: assert property (p_security)
    else $error("security bit read mismatch");

  property p_reset_cmd;
    @(posedge clk) disable iff (sys_rst)
    fl_wr && fl_dat == fprc_pkg::RESET_CMD_DAT |=> rcmd;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command write not recognised");

  property p_ignore;
    @(posedge clk) disable iff (sys_rst)
    rcmd && (state_r == fprc_pkg::FPRC_PROG ||
      state_r == fprc_pkg::FPRC_BULK) && !op_done && !op_error && !pin_rst
      |=> state_r == $past(state_r) && !op_abort;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("reset command acted during program or bulk erase");

  property p_small;
    @(posedge clk) disable iff (sys_rst)
    !large_variant && rcmd && (state_r == fprc_pkg::FPRC_READ ||
      state_r == fprc_pkg::FPRC_SECT)
      |=> state_r == fprc_pkg::FPRC_RECOV && !array_read_mode;
  endproperty
  a_small: assert property (p_small)
    else $error("small variant reset did not start recovery");

  property p_quick;
    @(posedge clk) disable iff (sys_rst)
    large_variant && rcmd && state_r == fprc_pkg::FPRC_READ && !error_r &&
      !pin_rst && !status_rd_req ##1 rst_pin_n |-> array_read_mode;
  endproperty
  a_quick: assert property (p_quick)
    else $error("large variant reset not immediate");

  property p_err_ret;
    @(posedge clk) disable iff (sys_rst)
    large_variant && rcmd && state_r == fprc_pkg::FPRC_READ && error_r &&
      !pin_rst
      |=> !array_read_mode [*8] ##[1:500] state_r == fprc_pkg::FPRC_READ;
  endproperty
  a_err_ret: assert property (p_err_ret)
    else $error("error reset return timing wrong");

  property p_abort;
    @(posedge clk) disable iff (sys_rst)
    large_variant && rcmd && state_r == fprc_pkg::FPRC_SECT
      |=> op_abort ##[1:500] state_r == fprc_pkg::FPRC_READ;
  endproperty
  a_abort: assert property (p_abort)
    else $error("sector erase not aborted in time");

  property p_pin;
    @(posedge clk) disable iff (sys_rst)
    pin_rst && in_op |=> op_abort && state_r == fprc_pkg::FPRC_RECOV;
  endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin did not abort operation");

  property p_batt;
    @(posedge clk) disable iff (sys_rst)
    batt_active |-> $past(ctrl_r[fprc_pkg::CTRL_BATT_EN_BIT] &&
      supply_below_bat && bat_powers_sram);
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery indicator without cause");

  property p_protect;
    @(posedge clk) disable iff (sys_rst)
    prog_req && prot_hit(tgt_secondary, tgt_sector, prot_main, prot_sec)
      |=> !op_go && state_r != fprc_pkg::FPRC_PROG;
  endproperty
  a_protect: assert property (p_protect)
    else $error("program started on protected sector");

  property p_holdoff;
    @(posedge clk) disable iff (sys_rst)
    state_r == fprc_pkg::FPRC_RECOV && tmr_busy |-> !array_read_mode;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("array reads during recovery");
endmodule // fprc_flash_ctrl

// File: rtl/fprc_pkg.sv
// constants, register map and state type for the flash protect/reset control
package fprc_pkg;
  // wishbone byte addresses
  localparam logic [7:0] ADR_MAIN_PROT = 8'h00;
  localparam logic [7:0] ADR_SEC_PROT  = 8'h04;
  localparam logic [7:0] ADR_CTRL      = 8'h08;
  localparam logic [7:0] ADR_MODE      = 8'h0C;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR   = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN    = 8'h18;
  // field positions
  localparam int SEC_SECURITY_BIT = 7;
  localparam int CTRL_BATT_EN_BIT = 0;
  localparam int MODE_ARRAY_BIT   = 0;
  localparam int MODE_ERROR_BIT   = 1;
  localparam int MODE_ID_BIT      = 2;
  localparam int MODE_UNLK_BIT    = 3;
  localparam int MODE_STATE_LSB   = 4;
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_IGN_BIT      = 1;
  localparam int IRQ_ERR_BIT      = 2;
  localparam int IRQ_W            = 3;
  // reset values
  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  // flash command cycles
  localparam logic [11:0] UNLK1_ADR     = 12'h555;
  localparam logic [7:0]  UNLK1_DAT     = 8'hAA;
  localparam logic [11:0] UNLK2_ADR     = 12'hAAA;
  localparam logic [7:0]  UNLK2_DAT     = 8'h55;
  localparam logic [7:0]  RESET_CMD_DAT = 8'hF0;
  // operation kinds
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_BULK = 2'h2;
  localparam logic [1:0] OP_SECT = 2'h3;
  // timing
  localparam int CLK_HZ          = 20000000;
  localparam int TMR_W           = 16;
  localparam int RECOV_US        = 25;
  localparam int RECOV_CYC       = (RECOV_US * CLK_HZ) / 1000000;
  localparam int SMALL_RESET_MS  = 2;
  localparam int SMALL_RESET_CYC = (SMALL_RESET_MS * CLK_HZ) / 1000;

  typedef enum logic [2:0] {
    FPRC_READ,
    FPRC_PROG,
    FPRC_BULK,
    FPRC_SECT,
    FPRC_RECOV
  } fprc_state_t;
endpackage

// File: rtl/fprc_cmd_decode.sv
// host write-cycle decoder: unlock sequence and reset command
`timescale 1ns/1ps
module fprc_cmd_decode (
  input  wire logic        clk,       // system clock
  input  wire logic        sys_rst,   // async reset, high
  input  wire logic        fl_wr,     // host write cycle strobe
  input  wire logic [11:0] fl_adr,    // host write address
  input  wire logic [7:0]  fl_dat,    // host write data
  output logic             reset_cmd, // one-cycle reset command pulse
  output logic             unlocked   // both unlock cycles seen
);
  logic [1:0] step_r;

  // the reset command is taken with or without the unlock prefix
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      step_r    <= 2'h0;
      reset_cmd <= 1'b0;
    end
    else
    begin
      reset_cmd <= fl_wr && (fl_dat == fprc_pkg::RESET_CMD_DAT);
      if (fl_wr)
      begin
        if (fl_dat == fprc_pkg::RESET_CMD_DAT)
          step_r <= 2'h0;
        else if (step_r == 2'h0)
          step_r <= (fl_adr == fprc_pkg::UNLK1_ADR &&
                     fl_dat == fprc_pkg::UNLK1_DAT) ? 2'h1 : 2'h0;
        else if (step_r == 2'h1)
          step_r <= (fl_adr == fprc_pkg::UNLK2_ADR &&
                     fl_dat == fprc_pkg::UNLK2_DAT) ? 2'h2 : 2'h0;
        else
          step_r <= 2'h0;
      end
    end
  end

  assign unlocked = (step_r == 2'h2);
endmodule // fprc_cmd_decode

// File: rtl/fprc_timer.sv
// down counter timing the return to array reads
`timescale 1ns/1ps
module fprc_timer (
  input  wire logic                     clk,      // system clock
  input  wire logic                     sys_rst,  // async reset, high
  input  wire logic                     load,     // start a new interval
  input  wire logic [fprc_pkg::TMR_W-1:0] load_val, // interval in cycles
  output logic                          busy,     // interval running
  output logic                          done      // last cycle of interval
);
  logic [fprc_pkg::TMR_W-1:0] cnt_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else if (load)
      cnt_r <= load_val;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign busy = (cnt_r != '0);
  assign done = (cnt_r == {{(fprc_pkg::TMR_W-1){1'b0}}, 1'b1}) && !load;
endmodule // fprc_timer

// File: verif/fprc_host_model.sv
// host model issuing flash write cycles
`timescale 1ns/1ps
module fprc_host_model (
  input  wire logic        clk,    // system clock
  output logic             fl_wr,  // write strobe
  output logic      [11:0] fl_adr, // write address
  output logic      [7:0]  fl_dat  // write data
);
  initial
  begin
    fl_wr = 1'b0;
    fl_adr = 12'h000;
    fl_dat = 8'h00;
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    {fl_wr, fl_adr, fl_dat} <= {1'b1, a, d};
    @(posedge clk);
    // released qualifiers must not keep looking valid
    {fl_wr, fl_adr, fl_dat} <= {1'b0, ~a, ~d};
  endtask
  task automatic rst_cmd(input logic unlk);
    if (unlk)
    begin
      wr(fprc_pkg::UNLK1_ADR, fprc_pkg::UNLK1_DAT);
      wr(fprc_pkg::UNLK2_ADR, fprc_pkg::UNLK2_DAT);
    end
    wr(12'h123, fprc_pkg::RESET_CMD_DAT);
  endtask
endmodule // fprc_host_model

// File: verif/fprc_flash_ctrl_bench.sv
// self-checking bench for the flash protect/reset control
`timescale 1ns/1ps
module fprc_flash_ctrl_bench;
  logic        clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic        prog_req, bulk_req, sect_req, tgt_secondary, op_done;
  logic        op_error, status_rd_req, security_set, rst_pin_n, op_go;
  logic        large_variant, supply_below_bat, bat_powers_sram, sram_en;
  logic        batt_active, array_read_mode, error_status_bit, op_abort;
  logic        fl_wr;
  logic [1:0]  op_kind, sram_pt;
  logic [2:0]  tgt_sector;
  logic [3:0]  wb_sel_i, prot_sec;
  logic [7:0]  wb_adr_i, prot_main, fl_dat;
  logic [11:0] fl_adr;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int          errors = 0, num_checks = 0, aborts = 0;

  fprc_flash_ctrl #(.SMALL_RST_CYC(50)) dut (
    .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .fl_wr, .fl_adr, .fl_dat,
    .prog_req, .bulk_req, .sect_req, .tgt_secondary, .tgt_sector, .op_done,
    .op_error, .status_rd_req, .prot_main, .prot_sec, .security_set,
    .rst_pin_n, .large_variant, .sram_pt, .supply_below_bat,
    .bat_powers_sram, .sram_en, .batt_active, .array_read_mode,
    .error_status_bit, .op_go, .op_kind, .op_abort
  );
  fprc_host_model host (.clk, .fl_wr, .fl_adr, .fl_dat);

  always #25 clk = ~clk;
  // abort pulses are single cycles, so count them instead of racing them
  always @(posedge clk)
  begin
    if (op_abort === 1'b1)
      aborts++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic nclk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    // data is taken at the edge that samples ack; the watchdog ends a hang
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic start(input logic [1:0] k, input logic [2:0] s,
                       input logic ok);
    @(posedge clk);
    tgt_sector <= s;
    {prog_req, bulk_req, sect_req} <= {k == 2'h1, k == 2'h2, k == 2'h3};
    @(posedge clk);
    {prog_req, bulk_req, sect_req} <= 3'h0;
    @(negedge clk);
    chk(op_go, ok);
    if (ok)
      chk(op_kind, k);
  endtask
  task automatic abort_run(input logic pin, input int cyc);
    int a;
    a = aborts;
    start(fprc_pkg::OP_SECT, 3'h0, 1'b1);
    if (pin)
      @(posedge clk) rst_pin_n <= 1'b0;
    else
      host.rst_cmd(1'b0);
    nclk(3);
    chk(aborts, a + 1);
    chk(array_read_mode, 1'b0);
    nclk(cyc - 8);
    chk(array_read_mode, 1'b0);
    // the pin pulse outlasts the recovery interval
    if (pin)
    begin
      repeat (8) @(posedge clk);
      rst_pin_n <= 1'b1;
    end
    nclk(12);
    chk(array_read_mode, 1'b1);
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    final_report;
  end

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, prog_req, bulk_req, sect_req, op_done,
     op_error, status_rd_req, tgt_secondary} = 10'h000;
    {supply_below_bat, bat_powers_sram, sram_pt, tgt_sector} = 7'h00;
    {wb_sel_i, wb_adr_i, wb_dat_i} = {4'hF, 8'h00, 32'h0};
    {prot_main, prot_sec, security_set, rst_pin_n, large_variant} =
      {8'h5A, 4'h9, 3'h7};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(fprc_pkg::ADR_MAIN_PROT, 32'h0000005A);
    rd(fprc_pkg::ADR_SEC_PROT, 32'h00000089);
    wb(1'b1, fprc_pkg::ADR_MAIN_PROT, 32'h000000FF);
    rd(fprc_pkg::ADR_MAIN_PROT, 32'h0000005A);
    rd(8'hFC, 32'h00000000);
    wb(1'b1, fprc_pkg::ADR_IRQ_EN, 32'h00000007);
    wb(1'b1, fprc_pkg::ADR_CTRL, 32'h00000001);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      sram_pt <= i[1:0];
      {supply_below_bat, bat_powers_sram} <= i[1:0];
      nclk(3);
      chk(sram_en, |i[1:0]);
      chk(batt_active, &i[1:0]);
    end
    @(posedge clk) status_rd_req <= 1'b1;
    @(posedge clk) status_rd_req <= 1'b0;
    nclk(2);
    chk(array_read_mode, 1'b0);
    host.rst_cmd(1'b1);
    nclk(3);
    chk(array_read_mode, 1'b1);
    rd(fprc_pkg::ADR_IRQ_STAT, 32'h00000001);
    chk(irq, 1'b1);
    wb(1'b1, fprc_pkg::ADR_IRQ_CLR, 32'h00000007);
    nclk(1);
    chk(irq, 1'b0);
    start(fprc_pkg::OP_PROG, 3'h0, 1'b1);
    host.rst_cmd(1'b0);
    nclk(3);
    rd(fprc_pkg::ADR_IRQ_STAT, 32'h00000002);
    @(posedge clk) op_done <= 1'b1;
    @(posedge clk) op_done <= 1'b0;
    start(fprc_pkg::OP_PROG, 3'h1, 1'b0);
    start(fprc_pkg::OP_BULK, 3'h0, 1'b0);
    start(fprc_pkg::OP_PROG, 3'h0, 1'b1);
    @(posedge clk) op_error <= 1'b1;
    @(posedge clk) op_error <= 1'b0;
    nclk(1);
    chk(error_status_bit, 1'b1);
    chk(array_read_mode, 1'b0);
    rd(fprc_pkg::ADR_IRQ_STAT, 32'h00000006);
    host.rst_cmd(1'b0);
    nclk(480);
    chk(array_read_mode, 1'b0);
    nclk(30);
    chk(array_read_mode, 1'b1);
    chk(error_status_bit, 1'b0);
    abort_run(1'b0, 500);
    abort_run(1'b1, 500);
    @(posedge clk) large_variant <= 1'b0;
    abort_run(1'b0, 50);
    final_report;
  end
endmodule // fprc_flash_ctrl_bench
